// [ata_wm_device.sv]
// Device end: block write command execution with sector FIFO toward the medium
`timescale 1ns/1ps

// ****************************************
// Sector word FIFO
// ****************************************
module ata_wm_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 32
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ata_wm_fifo

// ****************************************
// Command engine
// ****************************************
module ata_wm_device
	import ata_wm_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_WORDS,
	parameter int SPT        = CHS_SPT,
	parameter int HEADS      = CHS_HEADS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	ata_tf_if.dev            tf,
	input  wire logic [7:0]  mult_size,
	output logic             media_valid,
	output logic      [15:0] media_data,
	input  wire logic        media_ready,
	input  wire logic        media_err
);
	typedef enum logic [1:0] {S_IDLE, S_XFER, S_DRAIN} dev_state_t;

	dev_state_t  st_r;
	logic [7:0]  cnt_c_r, cnt_p_r, sn_c_r, sn_p_r, cl_c_r, cl_p_r, ch_c_r, ch_p_r, dh_r;
	logic [7:0]  err_r;
	logic [7:0]  word_r;
	logic [7:0]  blk_r;
	logic [16:0] rem_r;
	logic        first_r;
	logic        ext_r;
	logic        idn_r;
	logic        irq_r;
	logic [7:0]  rdata_r;
	logic        fifo_in_ready;
	logic        take;
	logic        sec_end;
	logic        adv;
	logic        cmd_wr;
	logic        drained;
	logic        done_evt;
	logic        stat_rd;
	logic [7:0]  status;
	logic [51:0] nxt;

	// Next sector address, {head, six address bytes}
	function automatic logic [51:0] addr_next(input logic [47:0] a, input logic [3:0] hd,
		input logic lba, input logic ext);
		logic [27:0] v;
		logic [7:0]  sn;
		logic [15:0] cyl;
		logic [3:0]  h;
		v   = {hd, a[23:0]} + 28'h1;
		sn  = a[7:0];
		cyl = a[23:8];
		h   = hd;
		if (ext) begin
			addr_next = {hd, a + 48'h1};
		end else if (lba) begin
			addr_next = {v[27:24], a[47:24], v[23:0]};
		end else begin
			if (sn >= 8'(SPT)) begin
				sn = 8'h01;
				if (h == 4'(HEADS-1)) begin
					h   = 4'h0;
					cyl = cyl + 16'h1;
				end else begin
					h = h + 4'h1;
				end
			end else begin
				sn = sn + 8'h01;
			end
			addr_next = {h, a[47:24], cyl, sn};
		end
	endfunction : addr_next

	assign take       = tf.data_wr && tf.data_ready;
	assign sec_end    = take && (word_r == 8'(SECTOR_WORDS-1));
	assign adv        = take && (word_r == 8'h00) && !first_r;
	assign cmd_wr     = tf.tf_wr && (tf.tf_addr == TF_CMD) && (st_r == S_IDLE);
	assign drained    = (st_r == S_DRAIN) && !media_valid;
	assign done_evt   = drained && (idn_r || rem_r == '0);
	assign stat_rd    = tf.tf_rd && (tf.tf_addr == TF_CMD);
	assign nxt        = addr_next({ch_p_r, cl_p_r, sn_p_r, ch_c_r, cl_c_r, sn_c_r}, dh_r[3:0],
		dh_r[DH_LBA], ext_r);
	assign tf.drq        = (st_r == S_XFER);
	assign tf.data_ready = (st_r == S_XFER) && fifo_in_ready;
	assign tf.intrq      = irq_r;
	assign tf.tf_rdata   = rdata_r;
	assign status = {st_r == S_DRAIN, 1'b1, 1'b0, 1'b1, st_r == S_XFER, 1'b0, 1'b0, err_r != 8'h00};

	ata_wm_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) ata_wm_fifo_i (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_valid  (tf.data_wr && (st_r == S_XFER)),
		.in_ready  (fifo_in_ready),
		.in_data   (tf.data_wdata),
		.out_valid (media_valid),
		.out_ready (media_ready),
		.out_data  (media_data)
	);

	// ****************************************
	// Task-file registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			{cnt_c_r, cnt_p_r, sn_c_r, sn_p_r, cl_c_r, cl_p_r, ch_c_r, ch_p_r} <= '0;
			dh_r <= DH_FIXED;
		end else if (tf.tf_wr && st_r == S_IDLE) begin
			case (tf.tf_addr)
				TF_CNT: {cnt_p_r, cnt_c_r} <= {cnt_c_r, tf.tf_wdata};
				TF_SN: {sn_p_r, sn_c_r} <= {sn_c_r, tf.tf_wdata};
				TF_CL: {cl_p_r, cl_c_r} <= {cl_c_r, tf.tf_wdata};
				TF_CH: {ch_p_r, ch_c_r} <= {ch_c_r, tf.tf_wdata};
				TF_DH: dh_r <= tf.tf_wdata;
				default: ;
			endcase
		end else begin
			if (adv) begin
				{dh_r[3:0], ch_p_r, cl_p_r, sn_p_r, ch_c_r, cl_c_r, sn_c_r} <= nxt;
			end
			if (done_evt) begin
				{cnt_p_r, cnt_c_r} <= rem_r[15:0];
			end
		end
	end

	// ****************************************
	// Command sequencing
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r    <= S_IDLE;
			err_r   <= 8'h00;
			word_r  <= 8'h00;
			blk_r   <= 8'h00;
			rem_r   <= '0;
			first_r <= 1'b0;
			ext_r   <= 1'b0;
			idn_r   <= 1'b0;
		end else begin
			if (media_err && st_r != S_IDLE) begin
				idn_r <= 1'b1;
			end
			case (st_r)
				S_IDLE: begin
					if (cmd_wr) begin
						word_r  <= 8'h00;
						blk_r   <= 8'h00;
						first_r <= 1'b1;
						idn_r   <= 1'b0;
						ext_r   <= (tf.tf_wdata == OP_WM_EXT);
						err_r   <= 8'h00;
						if ((tf.tf_wdata != OP_WM && tf.tf_wdata != OP_WM_EXT)
							|| mult_size == 8'h00) begin
							err_r[ER_ABT] <= 1'b1;
						end else begin
							st_r <= S_XFER;
							if (tf.tf_wdata == OP_WM_EXT) begin
								rem_r <= ({cnt_p_r, cnt_c_r} == 16'h0000) ? CNT48_ZERO
									: {1'b0, cnt_p_r, cnt_c_r};
							end else begin
								rem_r <= (cnt_c_r == 8'h00) ? CNT28_ZERO : {9'h000, cnt_c_r};
							end
						end
					end
				end
				S_XFER: begin
					if (take) begin
						word_r  <= word_r + 8'h01;
						first_r <= 1'b0;
					end
					if (sec_end) begin
						rem_r <= rem_r - 17'h1;
						if (rem_r == 17'h1 || blk_r == mult_size - 8'h01) begin
							st_r  <= S_DRAIN;
							blk_r <= 8'h00;
						end else begin
							blk_r <= blk_r + 8'h01;
						end
					end
				end
				S_DRAIN: begin
					if (drained) begin
						if (idn_r) begin
							err_r[ER_IDN] <= 1'b1;
							st_r          <= S_IDLE;
						end else begin
							st_r <= (rem_r == '0) ? S_IDLE : S_XFER;
						end
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Interrupt and read-back
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else if (drained || (cmd_wr && tf.tf_wdata != OP_WM && tf.tf_wdata != OP_WM_EXT)
			|| (cmd_wr && mult_size == 8'h00)) begin
			irq_r <= 1'b1;
		end else if (stat_rd) begin
			irq_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (tf.tf_rd) begin
			case (tf.tf_addr)
				TF_ERR: rdata_r <= err_r;
				TF_CNT: rdata_r <= tf.tf_hob ? cnt_p_r : cnt_c_r;
				TF_SN: rdata_r <= tf.tf_hob ? sn_p_r : sn_c_r;
				TF_CL: rdata_r <= tf.tf_hob ? cl_p_r : cl_c_r;
				TF_CH: rdata_r <= tf.tf_hob ? ch_p_r : ch_c_r;
				TF_DH: rdata_r <= dh_r;
				TF_CMD: rdata_r <= status;
				default: rdata_r <= 8'h00;
			endcase
		end
	end
endmodule : ata_wm_device

// [ata_wm_pkg.sv]
// Shared constants for the block write command path
package ata_wm_pkg;
	localparam logic [2:0]  TF_DATA    = 3'h0;
	localparam logic [2:0]  TF_ERR     = 3'h1;
	localparam logic [2:0]  TF_CNT     = 3'h2;
	localparam logic [2:0]  TF_SN      = 3'h3;
	localparam logic [2:0]  TF_CL      = 3'h4;
	localparam logic [2:0]  TF_CH      = 3'h5;
	localparam logic [2:0]  TF_DH      = 3'h6;
	localparam logic [2:0]  TF_CMD     = 3'h7;
	localparam logic [7:0]  OP_WM      = 8'hC5;
	localparam logic [7:0]  OP_WM_EXT  = 8'h39;
	localparam int          ST_BSY     = 7;
	localparam int          ST_RDY     = 6;
	localparam int          ST_DSC     = 4;
	localparam int          ST_DRQ     = 3;
	localparam int          ST_ERR     = 0;
	localparam int          ER_IDN     = 4;
	localparam int          ER_ABT     = 2;
	localparam int          DH_LBA     = 6;
	localparam logic [7:0]  DH_FIXED   = 8'hA0;
	localparam logic [16:0] CNT28_ZERO = 17'h00100;
	localparam logic [16:0] CNT48_ZERO = 17'h10000;
	localparam int          SECTOR_WORDS = 256;
	localparam int          FIFO_WORDS = 32;
	localparam int          CHS_SPT    = 63;
	localparam int          CHS_HEADS  = 16;
	localparam int          STEPS      = 10;
endpackage : ata_wm_pkg

// [ata_tf_if.sv]
// Task-file register and data port between host controller and device
`timescale 1ns/1ps
interface ata_tf_if;
	logic        tf_wr;
	logic        tf_rd;
	logic [2:0]  tf_addr;
	logic [7:0]  tf_wdata;
	logic        tf_hob;
	logic [7:0]  tf_rdata;
	logic        data_wr;
	logic [15:0] data_wdata;
	logic        data_ready;
	logic        drq;
	logic        intrq;
	modport dev  (input tf_wr, tf_rd, tf_addr, tf_wdata, tf_hob, data_wr, data_wdata,
		output tf_rdata, data_ready, drq, intrq);
	modport host (output tf_wr, tf_rd, tf_addr, tf_wdata, tf_hob, data_wr, data_wdata,
		input tf_rdata, data_ready, drq, intrq);
endinterface : ata_tf_if

// [ata_wm_host.sv]
// Host end: loads the task file, issues a block write and streams sector words
`timescale 1ns/1ps
module ata_wm_host
	import ata_wm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	ata_tf_if.host           tf,
	input  wire logic        cmd_start,
	input  wire logic        cmd_ext,
	input  wire logic        cmd_lba_mode,
	input  wire logic [47:0] cmd_addr,
	input  wire logic [15:0] cmd_count,
	input  wire logic        src_valid,
	input  wire logic [15:0] src_data,
	output logic             src_ready,
	output logic             cmd_busy,
	output logic             done,
	output logic      [7:0]  done_status,
	output logic      [7:0]  done_error
);
	typedef enum logic [2:0] {H_IDLE, H_LOAD, H_WAIT, H_DATA, H_STAT, H_ERR} host_state_t;

	host_state_t st_r;
	logic [3:0]  step_r;
	logic        ext_r;
	logic        lba_r;
	logic [47:0] addr_r;
	logic [15:0] count_r;
	logic [10:0] wr_cmd;

	// Register write for each load step, {addr, data}
	function automatic logic [10:0] step_write(input logic [3:0] s, input logic [47:0] a,
		input logic [15:0] c, input logic e, input logic l);
		case (s)
			4'h0: step_write = {TF_CNT, c[15:8]};
			4'h1: step_write = {TF_CNT, c[7:0]};
			4'h2: step_write = {TF_SN, a[31:24]};
			4'h3: step_write = {TF_SN, a[7:0]};
			4'h4: step_write = {TF_CL, a[39:32]};
			4'h5: step_write = {TF_CL, a[15:8]};
			4'h6: step_write = {TF_CH, a[47:40]};
			4'h7: step_write = {TF_CH, a[23:16]};
			4'h8: step_write = {TF_DH, DH_FIXED | {1'b0, e | l, 2'b00, a[27:24]}};
			default: step_write = {TF_CMD, e ? OP_WM_EXT : OP_WM};
		endcase
	endfunction : step_write

	assign wr_cmd        = step_write(step_r, addr_r, count_r, ext_r, lba_r);
	assign tf.tf_wr      = (st_r == H_LOAD);
	assign tf.tf_wdata   = wr_cmd[7:0];
	assign tf.tf_hob     = 1'b0;
	assign tf.tf_rd      = (st_r == H_WAIT && tf.intrq) || (st_r == H_STAT && !tf.tf_rdata[ST_DRQ]);
	assign tf.tf_addr    = (st_r == H_LOAD) ? wr_cmd[10:8] : (st_r == H_STAT) ? TF_ERR : TF_CMD;
	assign src_ready     = (st_r == H_DATA) && tf.drq && tf.data_ready;
	assign tf.data_wr    = (st_r == H_DATA) && tf.drq && src_valid;
	assign tf.data_wdata = src_data;
	assign cmd_busy      = (st_r != H_IDLE);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r        <= H_IDLE;
			step_r      <= 4'h0;
			ext_r       <= 1'b0;
			lba_r       <= 1'b0;
			addr_r      <= '0;
			count_r     <= '0;
			done        <= 1'b0;
			done_status <= 8'h00;
			done_error  <= 8'h00;
		end else begin
			done <= 1'b0;
			case (st_r)
				H_IDLE: begin
					if (cmd_start) begin
						ext_r   <= cmd_ext;
						lba_r   <= cmd_lba_mode;
						addr_r  <= cmd_addr;
						count_r <= cmd_count;
						step_r  <= 4'h0;
						st_r    <= H_LOAD;
					end
				end
				H_LOAD: begin
					step_r <= step_r + 4'h1;
					if (step_r == 4'(STEPS-1)) begin
						st_r <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (tf.intrq) begin
						st_r <= H_STAT;
					end else if (tf.drq) begin
						st_r <= H_DATA;
					end
				end
				H_DATA: begin
					if (!tf.drq) begin
						st_r <= H_WAIT;
					end
				end
				H_STAT: begin
					if (tf.tf_rdata[ST_DRQ]) begin
						st_r <= H_DATA;
					end else begin
						done_status <= tf.tf_rdata;
						st_r        <= H_ERR;
					end
				end
				H_ERR: begin
					done_error <= tf.tf_rdata;
					done       <= 1'b1;
					st_r       <= H_IDLE;
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end
endmodule : ata_wm_host

// [ata_block_write_command_monitor.sv]
// Protocol checker on the task-file interface between host and device ends
`timescale 1ns/1ps
module ata_block_write_command_monitor
	import ata_wm_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        tf_wr,
	input wire logic        tf_rd,
	input wire logic [2:0]  tf_addr,
	input wire logic [7:0]  tf_wdata,
	input wire logic        tf_hob,
	input wire logic [7:0]  tf_rdata,
	input wire logic        data_wr,
	input wire logic [15:0] data_wdata,
	input wire logic        data_ready,
	input wire logic        drq,
	input wire logic        intrq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ****************************************
	// Sequences
	// ****************************************
	sequence s_cnt_pair;
		$past(tf_wr, 9) && $past(tf_addr, 9) == TF_CNT && $past(tf_addr, 8) == TF_CNT;
	endsequence
	sequence s_dh_last;
		$past(tf_wr) && $past(tf_addr) == TF_DH;
	endsequence
	sequence s_status_rd;
		tf_rd && tf_addr == TF_CMD;
	endsequence
	// ****************************************
	// Properties
	// ****************************************
	property p_rdata_hold;
		!tf_rd |=> $stable(tf_rdata);
	endproperty
	property p_status_bits;
		s_status_rd |=> !tf_rdata[7] && !tf_rdata[5] && !tf_rdata[2] && tf_rdata[6] && tf_rdata[4]
			&& tf_rdata[3] == $past(drq);
	endproperty
	property p_err_bits;
		tf_rd && tf_addr == TF_ERR |=> (tf_rdata & 8'hEB) == 8'h00;
	endproperty
	property p_cmd_answer;
		tf_wr && tf_addr == TF_CMD && (tf_wdata == OP_WM || tf_wdata == OP_WM_EXT) |-> ##[1:8] (drq || intrq);
	endproperty
	property p_ready_drq;
		data_ready |-> drq;
	endproperty
	property p_drq_fall;
		$fell(drq) |-> !intrq;
	endproperty
	property p_intrq_hold;
		intrq && !(tf_rd && tf_addr == TF_CMD) |=> intrq;
	endproperty
	property p_load_order;
		tf_wr && tf_addr == TF_CMD |-> s_cnt_pair ##0 s_dh_last;
	endproperty
	property p_dh_bits;
		tf_wr && tf_addr == TF_DH |-> tf_wdata[7] && tf_wdata[5];
	endproperty
	// ****************************************
	// Assertions
	// ****************************************
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
	a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
	a_err_bits: assert property (p_err_bits) else $error("error bits outside IDN and ABT");
	a_cmd_answer: assert property (p_cmd_answer) else $error("opcode not answered");
	a_ready_drq: assert property (p_ready_drq) else $error("data ready without drq");
	a_drq_fall: assert property (p_drq_fall) else $error("interrupt before block drained");
	a_intrq_hold: assert property (p_intrq_hold) else $error("interrupt dropped without status read");
	a_load_order: assert property (p_load_order) else $error("task file load order wrong");
	a_dh_bits: assert property (p_dh_bits) else $error("device head fixed bits wrong");
endmodule : ata_block_write_command_monitor

// [ata_block_write_command_bench.sv]
// Testbench joining host and device ends with self-checking scenarios
`timescale 1ns/1ps
module ata_block_write_command_bench
	import ata_wm_pkg::*;
;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, cmd_start = 1'b0, cmd_ext = 1'b0, cmd_lba_mode = 1'b0;
	logic [47:0] cmd_addr = 48'h0;
	logic [15:0] cmd_count = 16'h0, src_data = 16'h0, media_data;
	logic        src_valid = 1'b0, src_ready, cmd_busy, done, media_valid, media_ready = 1'b0, media_err = 1'b0;
	logic [7:0]  done_status, done_error, mult_size = 8'h00;
	logic        intrq_d = 1'b0;
	int          err_total = 0, checked = 0, irq_n = 0;
	logic [15:0] words_q[$];
	logic [15:0] done_q[$];
	always #12.5 clk_sys = ~clk_sys;
	ata_tf_if ata_tf_if_i ();
	ata_wm_host ata_wm_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tf(ata_tf_if_i.host), .cmd_start(cmd_start),
		.cmd_ext(cmd_ext), .cmd_lba_mode(cmd_lba_mode), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready), .cmd_busy(cmd_busy), .done(done),
		.done_status(done_status), .done_error(done_error));
	ata_wm_device ata_wm_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tf(ata_tf_if_i.dev),
		.mult_size(mult_size), .media_valid(media_valid), .media_data(media_data),
		.media_ready(media_ready), .media_err(media_err));
	ata_block_write_command_monitor ata_block_write_command_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.tf_wr(ata_tf_if_i.tf_wr), .tf_rd(ata_tf_if_i.tf_rd), .tf_addr(ata_tf_if_i.tf_addr),
		.tf_wdata(ata_tf_if_i.tf_wdata), .tf_hob(ata_tf_if_i.tf_hob), .tf_rdata(ata_tf_if_i.tf_rdata),
		.data_wr(ata_tf_if_i.data_wr), .data_wdata(ata_tf_if_i.data_wdata), .data_ready(ata_tf_if_i.data_ready),
		.drq(ata_tf_if_i.drq), .intrq(ata_tf_if_i.intrq));
	// ****************************************
	// Compare and report
	// ****************************************
	task automatic chk(input string what, input logic [51:0] exp, input logic [51:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_word(input logic [15:0] got);
		if (words_q.size() == 0) chk("media word", 52'hFFFF, 52'(got));
		else chk("media word", 52'(words_q.pop_front()), 52'(got));
	endtask : chk_word
	task automatic chk_done(input logic [15:0] got);
		if (done_q.size() == 0) chk("done result", 52'hFFFF, 52'(got));
		else chk("done result", 52'(done_q.pop_front()), 52'(got));
	endtask : chk_done
	// Last transferred sector as {head, six address bytes}
	function automatic logic [51:0] exp_last(input logic ext, input logic lba, input logic [47:0] a, input int n);
		logic [47:0] r;
		int          k;
		r = a;
		for (k = 1; k < n; k++) begin
			if (ext || lba) begin
				r = ext ? r + 48'h1 : {r[47:28], r[27:0] + 28'h1};
			end else if (r[7:0] >= 8'(CHS_SPT)) begin
				r[7:0] = 8'h01;
				if (r[27:24] == 4'(CHS_HEADS - 1)) begin
					r[27:24] = 4'h0;
					r[23:8]  = r[23:8] + 16'h1;
				end else begin
					r[27:24] = r[27:24] + 4'h1;
				end
			end else begin
				r[7:0] = r[7:0] + 8'h01;
			end
		end
		exp_last = ext ? {a[27:24], r} : {r[27:24], a[47:24], r[23:0]};
	endfunction : exp_last
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// ****************************************
	// Source, sink and watchers
	// ****************************************
	always @(posedge clk_sys) begin
		if (src_valid === 1'b1 && src_ready === 1'b1) begin
			words_q.push_back(src_data);
			#1 src_data = 16'($urandom);
		end
	end
	always @(posedge clk_sys) begin
		#1 media_ready = ($urandom % 4) != 0;
	end
	always @(posedge clk_sys) begin
		if (media_valid === 1'b1 && media_ready === 1'b1) chk_word(media_data);
		if (done === 1'b1) chk_done({done_status, done_error});
		if (ata_tf_if_i.intrq === 1'b1 && intrq_d === 1'b0) irq_n++;
		intrq_d <= ata_tf_if_i.intrq;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic run(input string name, input logic ext, input logic lba, input logic [15:0] cnt,
		input logic [7:0] mult, input int err_at, input int blocks, input logic [15:0] res, input int secs,
		input logic [15:0] left);
		int          i;
		logic [51:0] regs;
		done_q.push_back(res);
		irq_n = 0;
		mult_size = mult;
		cmd_ext = ext;
		cmd_lba_mode = lba;
		cmd_count = cnt;
		cmd_addr = {16'($urandom), 32'($urandom)};
		if (!lba) cmd_addr = {20'h0, 4'($urandom % CHS_HEADS), 16'($urandom % 500),
			8'(CHS_SPT) - 8'($urandom % 2)};
		cmd_start = 1'b1;
		@(posedge clk_sys);
		#1 cmd_start = 1'b0;
		chk("busy at start", 52'h1, 52'(cmd_busy));
		for (i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1 media_err = (i == err_at);
		end
		if (i == 20000) begin
			err_total++;
			stop_test();
		end
		repeat (4) @(posedge clk_sys);
		#1 chk("interrupts", 52'(blocks), 52'(irq_n));
		chk("words left", 52'h0, 52'(words_q.size()));
		chk("count left", 52'(left), 52'({ata_wm_device_i.cnt_p_r, ata_wm_device_i.cnt_c_r}));
		regs = {ata_wm_device_i.dh_r[3:0], ata_wm_device_i.ch_p_r, ata_wm_device_i.cl_p_r,
			ata_wm_device_i.sn_p_r, ata_wm_device_i.ch_c_r, ata_wm_device_i.cl_c_r, ata_wm_device_i.sn_c_r};
		chk("last address", exp_last(ext, lba, cmd_addr, secs), regs);
		chk("busy at end", 52'h0, 52'(cmd_busy));
		$display("Test %s done", name);
	endtask : run
	initial begin
		void'($urandom(18621));
		repeat (20) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		src_valid = 1'b1;
		run("lba28 high count bits ignored", 1'b0, 1'b1, 16'hAB02, 8'h01, -1, 2, 16'h5000, 2, 16'h0000);
		run("ext two blocks", 1'b1, 1'b1, 16'h0003, 8'h02, -1, 2, 16'h5000, 3, 16'h0000);
		run("partial block", 1'b0, 1'b1, 16'h0001, 8'h04, -1, 1, 16'h5000, 1, 16'h0000);
		run("no block size abort", 1'b0, 1'b1, 16'h0002, 8'h00, -1, 1, 16'h5104, 0, 16'h0002);
		run("chs medium error", 1'b0, 1'b0, 16'h0002, 8'h01, 30, 1, 16'h5110, 1, 16'h0001);
		sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		chk("idle after reset", 52'h0, 52'({ata_tf_if_i.intrq, ata_tf_if_i.drq, ata_tf_if_i.tf_rdata}));
		run("chs wrap after reset", 1'b0, 1'b0, 16'h0003, 8'h02, -1, 2, 16'h5000, 3, 16'h0000);
		stop_test();
	end
endmodule : ata_block_write_command_bench
